// ===== src/sar_converter_control.sv
// Control logic of a 10-bit successive-approximation converter.
// Assumes an analog core that returns a result and a greater-than bit.
//
// What this block does
// - Enable bit zero powers the converter off, one powers it on.
// - Flag sets at conversion end, or in compare mode on input above value.
// - Hardware never clears the flag; software writes zero to clear.
// - Compare-mode bit selects conversion (0) or digital compare (1).
// - Channel field value n routes analog input n to the converter.
// - In conversion mode hardware clears the start bit at completion.
// - Software writing zero to start bit aborts a running conversion.
// - In compare mode the start bit stays set; compares repeat.
// - Writing one to start bit, with enable already set, launches conversion or continuous compare.
// - Reference bit selects supply (0) or external reference pin (1).
// - External reference gives the shared pin over to reference use.
// - Divider codes give 2,4,6,8,12,16,24,32 system clocks per period.
// - Sample phase lasts sample field plus one converter clocks.
// - Sample phase is at least two converter clocks.
// - Sample phase is at most fifteen converter clocks.
// - Twelve converter clocks of conversion follow the sample phase.
// - Each pin config bit makes its pin digital (0) or analog (1).
// - Set flag raises the interrupt request when interrupts are enabled.
// - Result upper eight bits and lowest two bits go to two registers.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module sar_converter_control
   import sar_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Interrupt
   input  wire logic       i_irq_enable,
   output logic            o_irq,
   // Analog core
   input  wire logic [9:0] i_core_result,
   input  wire logic       i_core_above,
   output logic            o_core_power,
   output logic      [2:0] o_core_channel,
   output logic            o_core_sample,
   output logic            o_core_convert,
   output logic            o_core_ext_ref,
   output logic            o_core_compare,
   // Pins
   output logic      [7:0] o_pin_analog,
   output logic            o_ref_pin_taken,
   output logic            o_rx_threshold
);

   // Register state
   logic       enable_q;
   logic       flag_q;
   logic       cmp_q;
   logic [2:0] chan_q;
   logic       go_q;
   logic [2:0] div_sel_q;
   logic [3:0] smp_sel_q;
   logic [7:0] pincfg_q;
   logic       ref_q;
   logic       rxth_q;
   logic [9:0] data_q;
   logic [7:0] rdata_q;
   logic       irq_q;
   logic       power_q;
   logic       sample_q;
   logic       convert_q;

   // Sequencer state
   phase_t     phase_q;
   phase_t     phase_d;
   logic [4:0] div_cnt_q;
   logic [3:0] tick_cnt_q;
   logic [3:0] tick_cnt_d;

   // Converter clock period in system clocks for each divider code
   function automatic logic [4:0] div_period(input logic [2:0] code);
      case (code)
         3'h0:    div_period = 5'h02;
         3'h1:    div_period = 5'h04;
         3'h2:    div_period = 5'h06;
         3'h3:    div_period = 5'h08;
         3'h4:    div_period = 5'h0C;
         3'h5:    div_period = 5'h10;
         3'h6:    div_period = 5'h18;
         default: div_period = 5'h00; // 32 wraps to zero in 5 bits
      endcase
   endfunction

   // Register decode
   wire logic wr_ctrl = i_wr && (i_addr == OFS_CONTROL);
   wire logic wr_time = i_wr && (i_addr == OFS_TIMING);
   wire logic wr_pin  = i_wr && (i_addr == OFS_PINCFG);
   wire logic wr_lo   = i_wr && (i_addr == OFS_RES_LO);
   wire logic wr_hi   = i_wr && (i_addr == OFS_RES_HI);
   wire logic wr_ref  = i_wr && (i_addr == OFS_REFSEL);

   // Clock divider: one-cycle tick each converter clock period
   wire logic [4:0] div_last  = div_period(div_sel_q) - 5'h01;
   wire logic       running   = (phase_q != ST_IDLE);
   wire logic       tick      = running && (div_cnt_q == div_last);

   // Sample length, clamped to the documented window
   wire logic [3:0] smp_raw   = smp_sel_q + 4'h1;
   wire logic [3:0] smp_len   = (smp_sel_q == 4'h0) ? SMP_MIN
                               : (smp_sel_q == 4'hF) ? SMP_MAX
                               : smp_raw;
   wire logic       smp_done  = tick && (phase_q == ST_SAMPLE)
                                && (tick_cnt_q == smp_len - 4'h1);
   wire logic       conv_done = tick && (phase_q == ST_CONV)
                                && (tick_cnt_q == CONV_CLOCKS - 4'h1);

   // Compare hit or conversion finish
   wire logic       finish    = conv_done && !cmp_q;
   wire logic       cmp_hit   = conv_done && cmp_q && i_core_above;

   // Software start and abort
   wire logic       sw_go_set = wr_ctrl && i_wdata[B_GO] && enable_q;
   wire logic       sw_go_clr = wr_ctrl && !i_wdata[B_GO];
   wire logic       active    = go_q && enable_q && !sw_go_clr;

   always_comb
   begin
      phase_d    = phase_q;
      tick_cnt_d = tick_cnt_q;
      case (phase_q)
         ST_IDLE:
         begin
            tick_cnt_d = 4'h0;
            if (sw_go_set)
               phase_d = ST_SAMPLE;
         end
         ST_SAMPLE:
         begin
            if (smp_done)
            begin
               phase_d    = ST_CONV;
               tick_cnt_d = 4'h0;
            end
            else if (tick)
               tick_cnt_d = tick_cnt_q + 4'h1;
         end
         ST_CONV:
         begin
            if (conv_done)
            begin
               // Compare mode loops back into a fresh sample
               phase_d    = cmp_q ? ST_SAMPLE : ST_IDLE;
               tick_cnt_d = 4'h0;
            end
            else if (tick)
               tick_cnt_d = tick_cnt_q + 4'h1;
         end
         default:
         begin
            phase_d    = ST_IDLE;
            tick_cnt_d = 4'h0;
         end
      endcase
      // Abort or power-off returns to idle
      if (running && !active)
      begin
         phase_d    = ST_IDLE;
         tick_cnt_d = 4'h0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         phase_q    <= ST_IDLE;
         tick_cnt_q <= 4'h0;
         div_cnt_q  <= 5'h00;
      end
      else
      begin
         phase_q    <= phase_d;
         tick_cnt_q <= tick_cnt_d;
         if (!running || tick)
            div_cnt_q <= 5'h00;
         else
            div_cnt_q <= div_cnt_q + 5'h01;
      end
   end

   // Control register
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         enable_q <= 1'b0;
         cmp_q    <= 1'b0;
         chan_q   <= 3'h0;
         go_q     <= 1'b0;
         flag_q   <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            enable_q <= i_wdata[B_ENABLE];
            cmp_q    <= i_wdata[B_CMP];
            chan_q   <= i_wdata[B_CH_HI:B_CH_LO];
         end
         if (sw_go_set)
            go_q <= 1'b1;
         else if (sw_go_clr || !enable_q)
            go_q <= 1'b0;
         else if (finish)
            go_q <= 1'b0;
         // Set wins over a software clear in the same cycle
         if (finish || cmp_hit)
            flag_q <= 1'b1;
         else if (wr_ctrl && !i_wdata[B_FLAG])
            flag_q <= 1'b0;
      end
   end

   // Timing, pin and reference registers
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         div_sel_q <= 3'h0;
         smp_sel_q <= 4'h0;
         pincfg_q  <= RST_BYTE;
         ref_q     <= 1'b0;
         rxth_q    <= 1'b0;
      end
      else
      begin
         if (wr_time)
         begin
            div_sel_q <= i_wdata[B_DIV_HI:B_DIV_LO];
            smp_sel_q <= i_wdata[B_SMP_HI:0];
         end
         if (wr_pin)
            pincfg_q <= i_wdata;
         if (wr_ref)
         begin
            ref_q  <= i_wdata[B_REF];
            rxth_q <= i_wdata[B_RXTH];
         end
      end
   end

   // Result or compare value; hardware update wins over software
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         data_q <= 10'h000;
      else if (finish)
         data_q <= i_core_result;
      else
      begin
         if (wr_hi)
            data_q[9:2] <= i_wdata;
         if (wr_lo)
            data_q[1:0] <= i_wdata[1:0];
      end
   end

   // Read mux
   wire logic [7:0] ctrl_view = {enable_q, flag_q, cmp_q, 1'b0,
                                 chan_q, go_q};
   wire logic [7:0] rd_mux =
        (i_addr == OFS_CONTROL) ? (ctrl_view & MASK_CTRL)
      : (i_addr == OFS_TIMING)  ? ({div_sel_q, 1'b0, smp_sel_q}
                                   & MASK_TIMING)
      : (i_addr == OFS_PINCFG)  ? pincfg_q
      : (i_addr == OFS_RES_LO)  ? {6'h00, data_q[1:0]}
      : (i_addr == OFS_RES_HI)  ? data_q[9:2]
      : (i_addr == OFS_REFSEL)  ? ({ref_q, 6'h00, rxth_q} & MASK_REF)
      : RST_BYTE;

   // Registered outputs
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rdata_q   <= RST_BYTE;
         irq_q     <= 1'b0;
         power_q   <= 1'b0;
         sample_q  <= 1'b0;
         convert_q <= 1'b0;
      end
      else
      begin
         rdata_q   <= i_rd ? rd_mux : RST_BYTE;
         irq_q     <= flag_q && i_irq_enable;
         power_q   <= enable_q;
         sample_q  <= (phase_d == ST_SAMPLE);
         convert_q <= (phase_d == ST_CONV);
      end
   end

   assign o_rdata         = rdata_q;
   assign o_irq           = irq_q;
   assign o_core_power    = power_q;
   assign o_core_channel  = chan_q;
   assign o_core_sample   = sample_q;
   assign o_core_convert  = convert_q;
   assign o_core_ext_ref  = ref_q;
   assign o_core_compare  = cmp_q;
   assign o_pin_analog    = pincfg_q;
   assign o_ref_pin_taken = ref_q;
   assign o_rx_threshold  = rxth_q;

endmodule
`default_nettype wire

// ===== src/sar_ctrl_pkg.sv
// Package for the converter control block: register map, fields, timing.
// Assumes an 8-bit special-function register port and a 25 MHz clock.
package sar_ctrl_pkg;
   localparam logic [7:0] OFS_CONTROL = 8'h93;
   localparam logic [7:0] OFS_TIMING  = 8'h94;
   localparam logic [7:0] OFS_PINCFG  = 8'h95;
   localparam logic [7:0] OFS_RES_LO  = 8'h96;
   localparam logic [7:0] OFS_RES_HI  = 8'h97;
   localparam logic [7:0] OFS_REFSEL  = 8'h9F;

   // Control register fields
   localparam int B_ENABLE  = 7;
   localparam int B_FLAG    = 6;
   localparam int B_CMP     = 5;
   localparam int B_CH_HI   = 3;
   localparam int B_CH_LO   = 1;
   localparam int B_GO      = 0;
   // Timing register fields
   localparam int B_DIV_HI  = 7;
   localparam int B_DIV_LO  = 5;
   localparam int B_SMP_HI  = 3;
   // Reference register fields
   localparam int B_REF     = 7;
   localparam int B_RXTH    = 0;

   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [7:0] MASK_CTRL   = 8'hEF;
   localparam logic [7:0] MASK_TIMING = 8'hEF;
   localparam logic [7:0] MASK_REF    = 8'h81;

   // Sample phase limits and conversion length in converter clocks; result width
   localparam logic [3:0] SMP_MIN     = 4'h2;
   localparam logic [3:0] SMP_MAX     = 4'hF;
   localparam logic [3:0] CONV_CLOCKS = 4'hC;
   localparam int         RES_BITS    = 10;

   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV   = 2'b11
   } phase_t;
endpackage

// ===== verif/sar_ctrl_checker.sv
// Port-level assertions for the converter control block.
// Assumes one clock; bound to the top module below.
`timescale 1ns/10ps
`default_nettype none
module sar_ctrl_checker
   import sar_ctrl_pkg::*;
(
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_irq_enable,
   input wire logic       o_irq,
   input wire logic [2:0] o_core_channel,
   input wire logic       o_core_sample,
   input wire logic       o_core_convert,
   input wire logic       o_core_ext_ref,
   input wire logic       o_core_compare,
   input wire logic [7:0] o_pin_analog,
   input wire logic       o_ref_pin_taken
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   wire ctl_w = i_wr && i_addr == OFS_CONTROL;

   chk_chan_follow: assert property (ctl_w |=>
      o_core_channel == $past(i_wdata[3:1])) else $error("channel");
   chk_cmp_follow: assert property (ctl_w |=>
      o_core_compare == $past(i_wdata[5])) else $error("compare bit");
   chk_ref_follow: assert property (i_wr && i_addr == OFS_REFSEL |=>
      o_core_ext_ref == $past(i_wdata[7])) else $error("reference");
   chk_ref_pin: assert property (
      o_ref_pin_taken == o_core_ext_ref) else $error("ref pin");
   chk_pin_cfg: assert property (i_wr && i_addr == OFS_PINCFG |=>
      o_pin_analog == $past(i_wdata)) else $error("pin config");
   chk_irq_cause: assert property (
      o_irq |-> $past(i_irq_enable)) else $error("irq");
   chk_phase_excl: assert property (
      !(o_core_sample && o_core_convert)) else $error("phases");
   chk_sample_min: assert property (
      $rose(o_core_sample) |-> o_core_sample[*4]) else $error("short");
   chk_sample_max: assert property (
      $rose(o_core_sample) |-> ##[4:480] !o_core_sample)
      else $error("long sample");
   chk_conv_len: assert property (
      $rose(o_core_convert) |-> o_core_convert[*8] ##[17:377]
      !o_core_convert) else $error("conversion length");

   cover property ($rose(o_core_convert) && o_core_compare);
   cover property ($rose(o_irq));
   cover property ($fell(o_core_convert) ##1 o_core_sample);
endmodule

bind sar_converter_control sar_ctrl_checker u_chk (.i_clk, .i_rst,
   .i_addr, .i_wdata, .i_wr, .i_irq_enable, .o_irq, .o_core_channel,
   .o_core_sample, .o_core_convert, .o_core_ext_ref, .o_core_compare,
   .o_pin_analog, .o_ref_pin_taken);
`default_nettype wire

// ===== verif/sar_core_model.sv
// Behavioural analog core: result encodes channel and reference.
// Assumes the block's convert and compare outputs.
`timescale 1ns/10ps
`default_nettype none
module sar_core_model
(
   input  wire logic       i_clk,
   input  wire logic       i_convert,
   input  wire logic       i_compare,
   input  wire logic [2:0] i_channel,
   input  wire logic       i_ext_ref,
   input  wire logic       i_above_req,
   output logic      [9:0] o_result,
   output logic            o_above
);
   // Outside conversion the value toggles, so no stale result passes
   initial
   begin
      o_result = 10'h155;
      forever @(posedge i_clk)
         o_result <= i_convert ? {i_channel, i_ext_ref, 6'h2B} : ~o_result;
   end
   assign o_above = i_convert & i_compare & i_above_req;
endmodule
`default_nettype wire

// ===== verif/sar_converter_control_test.sv
// Register-level bench for the converter control block.
// Assumes the core model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module sar_converter_control_test
   import sar_ctrl_pkg::*;
   ;
   logic       i_clk, i_rst, i_wr, i_rd, i_irq_enable, above_req;
   logic [7:0] i_addr, i_wdata, o_rdata, o_pin_analog;
   logic [9:0] core_result;
   logic       core_above, o_irq, o_core_power, o_core_sample;
   logic       o_core_convert, o_core_ext_ref, o_core_compare;
   logic       o_ref_pin_taken, o_rx_threshold;
   logic [2:0] o_core_channel;
   int         mismatches = 0, checks_done = 0, cycles = 0, ns, nc;
   int         per[8] = '{2, 4, 6, 8, 12, 16, 24, 32};

   sar_converter_control dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .i_irq_enable, .o_irq, .i_core_result(core_result),
      .i_core_above(core_above), .o_core_power, .o_core_channel,
      .o_core_sample, .o_core_convert, .o_core_ext_ref, .o_core_compare,
      .o_pin_analog, .o_ref_pin_taken, .o_rx_threshold);
   sar_core_model core (.i_clk, .i_convert(o_core_convert),
      .i_compare(o_core_compare), .i_channel(o_core_channel),
      .i_ext_ref(o_core_ext_ref), .i_above_req(above_req),
      .o_result(core_result), .o_above(core_above));

   initial
   begin
      i_clk = 0;
      forever #20 i_clk = ~i_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cycles++;
      // Whole run needs about 3000 cycles
      if (cycles == 20000)
      begin
         mismatches++;
         end_sim;
      end
   end

   task automatic chk(input string n, input logic [9:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rdc(input string n, input logic [7:0] a, e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(n, {2'b00, o_rdata}, {2'b00, e});
   endtask

   task automatic run(input logic [2:0] c, input logic [3:0] ts);
      int p, smp;
      p = per[c];
      smp = ts == 0 ? 2 : ts == 15 ? 15 : ts + 1;
      wr(OFS_TIMING, {c, 1'b0, ts});
      // Enable first: a start written while disabled is refused
      wr(OFS_CONTROL, {4'h8, c, 1'b0});
      wr(OFS_CONTROL, {4'h8, c, 1'b1});
      ns = 0;
      nc = 0;
      wait (o_core_sample);
      while (o_core_sample)
      begin
         @(posedge i_clk);
         #1 ns++;
      end
      while (o_core_convert)
      begin
         @(posedge i_clk);
         #1 nc++;
      end
      chk("sample", 10'(ns), 10'(smp * p));
      chk("convert", 10'(nc), 10'(12 * p));
      chk("power", 10'(o_core_power), 10'h1);
      rdc("control", OFS_CONTROL, {4'hC, c, 1'b0});
      rdc("res_hi", OFS_RES_HI, {c, 5'h0A});
      rdc("res_lo", OFS_RES_LO, 8'h03);
      chk("irq", 10'(o_irq), 10'h1);
      wr(OFS_CONTROL, {4'h8, c, 1'b0});
      rdc("control", OFS_CONTROL, {4'h8, c, 1'b0});
   endtask

   initial
   begin
      i_rst = 1;
      i_wr = 0;
      i_rd = 0;
      i_addr = 0;
      i_wdata = 0;
      i_irq_enable = 0;
      above_req = 0;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      rdc("control", OFS_CONTROL, RST_BYTE);
      rdc("timing", OFS_TIMING, RST_BYTE);
      rdc("refsel", OFS_REFSEL, RST_BYTE);
      rdc("unmapped", 8'h90, 8'h00);
      wr(OFS_CONTROL, 8'h01);
      repeat (4) @(posedge i_clk);
      #1 chk("sample", 10'(o_core_sample), 10'h0);
      chk("power", 10'(o_core_power), 10'h0);
      $display("test reset done");
      i_irq_enable <= 1'b1;
      for (int c = 0; c < 8; c++)
         run(3'(c), c == 7 ? 4'hF : 4'(2 * c));
      $display("test timing done");
      wr(OFS_TIMING, 8'hE0);
      wr(OFS_CONTROL, 8'h81);
      wait (o_core_convert);
      // Abort well inside the conversion phase
      repeat (30) @(posedge i_clk);
      wr(OFS_CONTROL, 8'h80);
      repeat (2) @(posedge i_clk);
      #1 chk("convert", 10'(o_core_convert), 10'h0);
      rdc("control", OFS_CONTROL, 8'h80);
      $display("test abort done");
      wr(OFS_RES_HI, 8'h3C);
      wr(OFS_RES_LO, 8'h01);
      wr(OFS_TIMING, 8'h00);
      wr(OFS_CONTROL, 8'hA1);
      repeat (70) @(posedge i_clk);
      rdc("control", OFS_CONTROL, 8'hA1);
      above_req <= 1'b1;
      repeat (40) @(posedge i_clk);
      rdc("control", OFS_CONTROL, 8'hE1);
      rdc("res_hi", OFS_RES_HI, 8'h3C);
      rdc("res_lo", OFS_RES_LO, 8'h01);
      above_req <= 1'b0;
      // Start of a conversion, so the abort never cuts a sample short
      @(posedge o_core_convert);
      repeat (10) @(posedge i_clk);
      wr(OFS_CONTROL, 8'hA0);
      repeat (70) @(posedge i_clk);
      #1 chk("sample", 10'(o_core_sample), 10'h0);
      $display("test compare done");
      wr(OFS_REFSEL, 8'hFF);
      rdc("refsel", OFS_REFSEL, MASK_REF);
      chk("ref_pin", 10'(o_ref_pin_taken), 10'h1);
      chk("rx_th", 10'(o_rx_threshold), 10'h1);
      wr(OFS_PINCFG, 8'hA5);
      rdc("pincfg", OFS_PINCFG, 8'hA5);
      chk("pins", 10'(o_pin_analog), 10'h0A5);
      wr(OFS_TIMING, 8'hFF);
      rdc("timing", OFS_TIMING, MASK_TIMING);
      wr(OFS_CONTROL, 8'h3E);
      rdc("control", OFS_CONTROL, 8'h2E);
      chk("channel", 10'(o_core_channel), 10'h7);
      $display("test registers done");
      end_sim;
   end
endmodule
`default_nettype wire
